// ### hdl/ccp_map.vh
// Register offsets, field positions, mode codes and reset values of the unit
`ifndef CCP_MAP_VH
`define CCP_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_VALUE_LOW 8'h15
`define OFS_VALUE_HIGH 8'h16
`define OFS_CONTROL 8'h17
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h19
// ****************************************
// Control fields
// ****************************************
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 3
`define CTL_DUTY_BIT_0 4
`define CTL_DUTY_BIT_1 5
`define CTL_WRITE_MASK 8'h3F
`define CTL_RESET 8'h00
// ****************************************
// Mode codes
// ****************************************
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'hA
`define MODE_CMP_TRIG 4'hB
// ****************************************
// Interrupt status bits and other positions
// ****************************************
`define IRQ_CAPTURE 0
`define IRQ_COMPARE 1
`define IRQ_PWM_PERIOD 2
`define IRQ_BITS 3
`define IRQ_RESET 3'h0
`define CFG_ROUTE_BIT 12
`define VALUE_RESET 8'h00
`endif

// ### hdl/capture_prescaler.v
// Capture edge detector with 1, 4 or 16 rising edge prescaler
`timescale 1ns/1ps
`default_nettype none
module capture_prescaler (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire pin,
    input wire [1:0] sel,
    output reg event_q
);
    reg pin_q;
    reg [3:0] count_q;
    wire rise;
    wire fall;
    reg hit;

    assign rise = pin & ~pin_q;
    assign fall = ~pin & pin_q;

    // Select which edge or edge count makes an event
    always @* begin
        case (sel)
            2'h0: hit = fall;
            2'h1: hit = rise;
            2'h2: hit = rise & (count_q[1:0] == 2'h3);
            default: hit = rise & (count_q == 4'hF);
        endcase
    end

    // Counter cleared whenever capture is off, so capture entered from another kind of mode starts at zero;
    // the pin sample keeps tracking, so a pin already high gives no false edge
    always @(posedge clk) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin;
        end
        if (!rst_n || clear) begin
            count_q <= 4'h0;
            event_q <= 1'b0;
        end else begin
            event_q <= hit;
            if (rise) begin
                count_q <= count_q + 4'h1;
            end
        end
    end
endmodule // capture_prescaler
`default_nettype wire

// ### hdl/pwm_duty.v
// Ten bit duty comparator against the period timer
`timescale 1ns/1ps
`default_nettype none
module pwm_duty (
    input wire clk,
    input wire rst_n,
    input wire enable,
    input wire [9:0] duty,
    input wire [7:0] count,
    input wire [1:0] phase,
    input wire wrap,
    output reg pwm_q
);
    reg [9:0] duty_q;

    // Duty is latched only at the period edge to avoid glitched pulses
    always @(posedge clk) begin
        if (!rst_n || !enable) begin
            duty_q <= 10'h000;
            pwm_q <= 1'b0;
        end else if (wrap) begin
            duty_q <= duty;
            pwm_q <= (duty != 10'h000);
        end else begin
            pwm_q <= ({count, phase} < duty_q);
        end
    end
endmodule // pwm_duty
`default_nettype wire

// ### hdl/cap_cmp_pwm_unit.v
// Capture, compare and PWM unit with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ccp_map.vh"
module cap_cmp_pwm_unit (
    input wire SYS_CLK,
    input wire RST_B,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    input wire [15:0] WIDE_TIMER_COUNT,
    input wire [7:0] PERIOD_TIMER_COUNT,
    input wire [1:0] PERIOD_TIMER_PHASE,
    input wire PERIOD_TIMER_WRAP,
    input wire ADC_ENABLED,
    input wire [13:0] CONFIG_WORD,
    input wire PORT_PIN_A_IN,
    input wire PORT_PIN_B_IN,
    output reg PORT_PIN_A_OUT,
    output reg PORT_PIN_A_OE,
    output reg PORT_PIN_B_OUT,
    output reg PORT_PIN_B_OE,
    output reg WIDE_TIMER_RESET,
    output reg WIDE_TIMER_RESET_NO_OVF,
    output reg ADC_START,
    output reg UNIT_IRQ_FLAG,
    output reg IRQ
);
    // ****************************************
    // Mode decoding
    // ****************************************
    // One-hot kind of the current mode
    localparam [3:0] K_OFF = 4'b0001;
    localparam [3:0] K_CAPTURE = 4'b0010;
    localparam [3:0] K_COMPARE = 4'b0100;
    localparam [3:0] K_PWM = 4'b1000;

    // Map a mode field to its one-hot kind; unused codes act as off
    function [3:0] mode_kind;
        input [3:0] m;
        begin
            if (m[3:2] == 2'b11) begin
                mode_kind = K_PWM;
            end else if (m[3:2] == 2'b10) begin
                mode_kind = K_COMPARE;
            end else if (m[3:2] == 2'b01) begin
                mode_kind = K_CAPTURE;
            end else begin
                mode_kind = K_OFF;
            end
        end
    endfunction

    // Address match, shared by the write strobes and the read mux
    function addr_is;
        input [7:0] a;
        input [7:0] ofs;
        begin
            addr_is = (a == ofs);
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    // Software visible state and pipeline flops
    reg [7:0] value_low_q;
    reg [7:0] value_high_q;
    reg [5:0] control_q;
    reg [`IRQ_BITS-1:0] status_q;
    reg [`IRQ_BITS-1:0] status_d;
    reg [`IRQ_BITS-1:0] mask_q;
    reg route_q;
    reg route_loaded_q;
    reg match_q;
    reg latch_q;
    reg [7:0] rdata_d;

    // Decoded mode, event and strobe nets
    wire [3:0] mode;
    wire [3:0] kind;
    wire capture_event;
    wire pwm_level;
    wire unit_pin_in;
    wire match;
    wire match_event;
    wire [15:0] value;
    wire wr_low;
    wire wr_high;
    wire wr_ctl;
    wire wr_status;
    wire wr_mask;

    // Terms shared by the capture, trigger and pin paths
    wire cap_hit;
    wire trig_event;
    wire drive_pin;
    wire pin_level;
    wire [7:0] ctl_reset_full;

    // Mode field and the value register as one word
    assign mode = control_q[`CTL_MODE_MSB:`CTL_MODE_LSB];
    assign kind = mode_kind(mode);
    assign value = {value_high_q, value_low_q};
    // Reset image of the control register; only its low six bits exist
    assign ctl_reset_full = `CTL_RESET;

    // One write strobe per mapped register
    assign wr_low = REG_WR && addr_is(REG_ADDR, `OFS_VALUE_LOW);
    assign wr_high = REG_WR && addr_is(REG_ADDR, `OFS_VALUE_HIGH);
    assign wr_ctl = REG_WR && addr_is(REG_ADDR, `OFS_CONTROL);
    assign wr_status = REG_WR && addr_is(REG_ADDR, `OFS_IRQ_STATUS);
    assign wr_mask = REG_WR && addr_is(REG_ADDR, `OFS_IRQ_MASK);

    // ****************************************
    // Pin routing strap
    // ****************************************
    // Configuration bit is caught once after reset release, not under reset
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            route_loaded_q <= 1'b0;
            route_q <= 1'b0;
        end else if (!route_loaded_q) begin
            route_loaded_q <= 1'b1;
            route_q <= CONFIG_WORD[`CFG_ROUTE_BIT];
        end
    end

    // The port pin that is not routed is ignored by the capture logic
    assign unit_pin_in = route_q ? PORT_PIN_B_IN : PORT_PIN_A_IN;

    // ****************************************
    // Capture path
    // ****************************************
    // Prescaler is held clear outside capture, so entering capture restarts the count; a change between capture modes keeps it
    capture_prescaler u_capture (
        .clk(SYS_CLK),
        .rst_n(RST_B),
        .clear(kind != K_CAPTURE),
        .pin(unit_pin_in),
        .sel(mode[1:0]),
        .event_q(capture_event)
    );

    // An event only counts while capture is still selected
    assign cap_hit = capture_event && (kind == K_CAPTURE);

    // ****************************************
    // Compare path
    // ****************************************
    // Compare runs against the wide timer every cycle
    assign match = (kind == K_COMPARE) && (WIDE_TIMER_COUNT == value);
    // One action per match, even if the timer dwells on the value
    assign match_event = match && !match_q;
    // Special event trigger fires on that same single match
    assign trig_event = match_event && (mode == `MODE_CMP_TRIG);

    // Compare output latch; forced low whenever the unit is off
    always @(posedge SYS_CLK) begin
        if (!RST_B || kind == K_OFF) begin
            match_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            match_q <= match;
            // Soft interrupt and trigger codes leave the latch alone
            if (match_event && mode == `MODE_CMP_SET) begin
                latch_q <= 1'b1;
            end else if (match_event && mode == `MODE_CMP_CLEAR) begin
                latch_q <= 1'b0;
            end
        end
    end

    // Special event trigger outputs, single cycle pulses
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            WIDE_TIMER_RESET <= 1'b0;
            WIDE_TIMER_RESET_NO_OVF <= 1'b0;
            ADC_START <= 1'b0;
        end else begin
            WIDE_TIMER_RESET <= trig_event;
            // Tells the timer this reset is no overflow
            WIDE_TIMER_RESET_NO_OVF <= trig_event;
            ADC_START <= trig_event && ADC_ENABLED;
        end
    end

    // ****************************************
    // PWM path
    // ****************************************
    // Duty takes effect at the next period wrap, never in mid-period
    // Period wraps also raise a status bit in the interrupt block
    pwm_duty u_pwm (
        .clk(SYS_CLK),
        .rst_n(RST_B),
        .enable(kind == K_PWM),
        .duty({value_low_q, control_q[`CTL_DUTY_BIT_1], control_q[`CTL_DUTY_BIT_0]}),
        .count(PERIOD_TIMER_COUNT),
        .phase(PERIOD_TIMER_PHASE),
        .wrap(PERIOD_TIMER_WRAP),
        .pwm_q(pwm_level)
    );

    // ****************************************
    // Register writes
    // ****************************************
    // Control register; unimplemented bits 7 and 6 are never stored
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            control_q <= ctl_reset_full[5:0];
            mask_q <= `IRQ_RESET;
        end else begin
            if (wr_ctl) begin
                control_q <= REG_WDATA[5:0];
            end
            if (wr_mask) begin
                mask_q <= REG_WDATA[`IRQ_BITS-1:0];
            end
        end
    end

    // Value bytes; a capture beats a software write in the same cycle
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            value_low_q <= `VALUE_RESET;
            value_high_q <= `VALUE_RESET;
        end else if (cap_hit) begin
            value_low_q <= WIDE_TIMER_COUNT[7:0];
            value_high_q <= WIDE_TIMER_COUNT[15:8];
        end else begin
            // Written bytes are independent; only a capture latches the pair together
            if (wr_low) begin
                value_low_q <= REG_WDATA;
            end
            if (wr_high) begin
                value_high_q <= REG_WDATA;
            end
        end
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    // Write one to clear; a new event in the same cycle keeps its bit set
    always @* begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_q & ~REG_WDATA[`IRQ_BITS-1:0];
        end
        // Events come after the clear so that a set in the same cycle wins
        if (cap_hit) begin
            status_d[`IRQ_CAPTURE] = 1'b1;
        end
        if (match_event) begin
            status_d[`IRQ_COMPARE] = 1'b1;
        end
        if (PERIOD_TIMER_WRAP && kind == K_PWM) begin
            status_d[`IRQ_PWM_PERIOD] = 1'b1;
        end
    end

    // Interrupt outputs follow the next status, so they rise with the bit
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            status_q <= `IRQ_RESET;
            UNIT_IRQ_FLAG <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            status_q <= status_d;
            UNIT_IRQ_FLAG <= status_d[`IRQ_CAPTURE] | status_d[`IRQ_COMPARE];
            IRQ <= |(status_d & mask_q);
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Pin is an output only in compare and PWM; capture needs it as an input
    assign drive_pin = (kind == K_COMPARE) || (kind == K_PWM);
    // Compare latch or PWM level, whichever mode owns the pin
    assign pin_level = (kind == K_PWM) ? pwm_level : latch_q;

    // Only the routed pin is driven; both outputs carry the same level
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            PORT_PIN_A_OUT <= 1'b0;
            PORT_PIN_A_OE <= 1'b0;
            PORT_PIN_B_OUT <= 1'b0;
            PORT_PIN_B_OE <= 1'b0;
        end else begin
            PORT_PIN_A_OUT <= pin_level;
            PORT_PIN_B_OUT <= pin_level;
            PORT_PIN_A_OE <= !route_q && drive_pin;
            PORT_PIN_B_OE <= route_q && drive_pin;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    // Unmapped addresses read as zero
    always @* begin
        rdata_d = 8'h00;
        if (addr_is(REG_ADDR, `OFS_VALUE_LOW)) begin
            rdata_d = value_low_q;
        end else if (addr_is(REG_ADDR, `OFS_VALUE_HIGH)) begin
            rdata_d = value_high_q;
        end else if (addr_is(REG_ADDR, `OFS_CONTROL)) begin
            rdata_d = {2'b00, control_q};
        end else if (addr_is(REG_ADDR, `OFS_IRQ_STATUS)) begin
            rdata_d = {5'h00, status_q};
        end else if (addr_is(REG_ADDR, `OFS_IRQ_MASK)) begin
            rdata_d = {5'h00, mask_q};
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_d;
        end else begin
            REG_RDATA <= 8'h00;
        end
    end
endmodule // cap_cmp_pwm_unit
`default_nettype wire

// ### hdl/end.v
`timescale 1ns/1ps

// ### test/cap_cmp_pwm_unit_asserts.sv
// Concurrent checks on the ports of the capture, compare and PWM unit
`timescale 1ns/1ps
`default_nettype none
module ccp_checker (
    input wire SYS_CLK,
    input wire RST_B,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    input wire ADC_ENABLED,
    input wire PORT_PIN_A_OE,
    input wire PORT_PIN_B_OE,
    input wire WIDE_TIMER_RESET,
    input wire WIDE_TIMER_RESET_NO_OVF,
    input wire ADC_START,
    input wire UNIT_IRQ_FLAG
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    // ****************************************
    // Control register steps
    // ****************************************
    sequence s_ctl_wr;
        REG_WR && REG_ADDR == 8'h17;
    endsequence
    sequence s_ctl_rd;
        REG_RD && REG_ADDR == 8'h17;
    endsequence
    sequence s_off_wr;
        s_ctl_wr ##0 REG_WDATA[3:0] == 4'h0;
    endsequence
    // Upper two bits never stored, so readback is masked
    a_ctl_readback: assert property (s_ctl_wr ##2 s_ctl_rd |=>
        REG_RDATA == ($past(REG_WDATA, 3) & 8'h3F)) else $error("control readback wrong");
    a_off_quiet: assert property (s_off_wr |-> ##2 (!PORT_PIN_A_OE && !PORT_PIN_B_OE) [*2])
        else $error("pin still driven after disable");
    a_read_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");
    a_read_unmapped: assert property ($past(REG_RD) && ($past(REG_ADDR) < 8'h15 ||
        $past(REG_ADDR) > 8'h19) |-> REG_RDATA == 8'h00) else $error("unmapped read not zero");
    // Only one port pin may carry the unit
    a_pin_route: assert property (!(PORT_PIN_A_OE && PORT_PIN_B_OE))
        else $error("both pins driven");
    // Trigger pulses and their companions
    a_trig_pair: assert property (WIDE_TIMER_RESET == WIDE_TIMER_RESET_NO_OVF)
        else $error("overflow suppress not paired");
    a_trig_pulse: assert property (WIDE_TIMER_RESET |=> !WIDE_TIMER_RESET)
        else $error("timer reset longer than one cycle");
    a_adc_gate: assert property (ADC_START |-> WIDE_TIMER_RESET && $past(ADC_ENABLED))
        else $error("conversion start without cause");
    a_adc_fire: assert property (WIDE_TIMER_RESET && $past(ADC_ENABLED) |-> ADC_START)
        else $error("conversion start missing");
    a_trig_flag: assert property ($rose(WIDE_TIMER_RESET) |-> ##[0:1] UNIT_IRQ_FLAG)
        else $error("trigger without flag");
endmodule // ccp_checker
bind cap_cmp_pwm_unit ccp_checker u_chk (.SYS_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .ADC_ENABLED, .PORT_PIN_A_OE, .PORT_PIN_B_OE, .WIDE_TIMER_RESET,
    .WIDE_TIMER_RESET_NO_OVF, .ADC_START, .UNIT_IRQ_FLAG);
`default_nettype wire

// ### test/ccp_far_side.sv
// Model of the pins and timers around the unit
`timescale 1ns/1ps
`default_nettype none
module ccp_far_side (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ld,
    input wire logic [15:0] ld_val,
    input wire logic run,
    input wire logic lvl,
    input wire logic tmr_rst,
    input wire logic a_out,
    input wire logic a_oe,
    input wire logic b_out,
    input wire logic b_oe,
    output logic [15:0] tmr_q,
    output logic [9:0] per_q,
    output logic wrap,
    output logic a_in,
    output logic b_in
);
    // Wide timer halts when not running so captures are predictable
    always @(posedge clk) begin
        if (!rst_n || tmr_rst) tmr_q <= 16'h0000;
        else if (ld) tmr_q <= ld_val;
        else if (run) tmr_q <= tmr_q + 16'h0001;
    end
    // Period timer count and phase as one free running counter
    always @(posedge clk) begin
        if (!rst_n) per_q <= 10'h000;
        else per_q <= per_q + 10'h001;
    end
    assign wrap = per_q == 10'h000;
    // Pin follows the unit while driven, else the outside source
    assign a_in = a_oe ? a_out : lvl;
    assign b_in = b_oe ? b_out : lvl;
endmodule // ccp_far_side
`default_nettype wire

// ### test/tb_capture_compare_pwm_unit.sv
// Self-checking bench for the capture, compare and PWM unit
`timescale 1ns/1ps
`default_nettype none
module tb_capture_compare_pwm_unit;
    logic SYS_CLK, RST_B, REG_WR, REG_RD, ADC_ENABLED, ld, run, lvl;
    logic [7:0] REG_ADDR, REG_WDATA, d;
    logic [13:0] CONFIG_WORD;
    logic [15:0] ld_val, v;
    logic [31:0] seed;
    wire [7:0] REG_RDATA;
    wire [15:0] WIDE_TIMER_COUNT;
    wire [9:0] per;
    wire PERIOD_TIMER_WRAP, PORT_PIN_A_IN, PORT_PIN_B_IN, PORT_PIN_A_OUT, PORT_PIN_A_OE;
    wire PORT_PIN_B_OUT, PORT_PIN_B_OE, WIDE_TIMER_RESET, WIDE_TIMER_RESET_NO_OVF;
    wire ADC_START, UNIT_IRQ_FLAG, IRQ;
    int errors, tests_run, i, k;
    cap_cmp_pwm_unit uut (.SYS_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
        .WIDE_TIMER_COUNT, .PERIOD_TIMER_COUNT(per[9:2]), .PERIOD_TIMER_PHASE(per[1:0]),
        .PERIOD_TIMER_WRAP, .ADC_ENABLED, .CONFIG_WORD, .PORT_PIN_A_IN, .PORT_PIN_B_IN,
        .PORT_PIN_A_OUT, .PORT_PIN_A_OE, .PORT_PIN_B_OUT, .PORT_PIN_B_OE, .WIDE_TIMER_RESET,
        .WIDE_TIMER_RESET_NO_OVF, .ADC_START, .UNIT_IRQ_FLAG, .IRQ);
    ccp_far_side far (.clk(SYS_CLK), .rst_n(RST_B), .ld, .ld_val, .run, .lvl,
        .tmr_rst(WIDE_TIMER_RESET), .a_out(PORT_PIN_A_OUT), .a_oe(PORT_PIN_A_OE),
        .b_out(PORT_PIN_B_OUT), .b_oe(PORT_PIN_B_OE), .tmr_q(WIDE_TIMER_COUNT), .per_q(per),
        .wrap(PERIOD_TIMER_WRAP), .a_in(PORT_PIN_A_IN), .b_in(PORT_PIN_B_IN));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Pin pulses needed for one capture in each capture mode
    function automatic int edges(input logic [3:0] m);
        return m == 4'h6 ? 4 : m == 4'h7 ? 16 : 1;
    endfunction
    // Ten bit duty from the low value byte and control bits 5 and 4
    function automatic logic [15:0] duty_of(input logic [7:0] lo, input logic [7:0] c);
        return {6'h00, lo, c[5], c[4]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    // Bus cycles start on an edge and leave one idle cycle after
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge SYS_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= w;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge SYS_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic ldt(input logic [15:0] x);
        @(posedge SYS_CLK);
        ld <= 1'b1;
        ld_val <= x;
        @(posedge SYS_CLK);
        ld <= 1'b0;
        #1;
    endtask
    task automatic pin(input logic b);
        @(posedge SYS_CLK);
        lvl <= b;
        cyc(4);
    endtask
    // Timer frozen at a fresh value before each pulse; last one is kept
    task automatic cap(input logic [3:0] m);
        wr(8'h17, 8'h00);
        wr(8'h17, {4'h0, m});
        wr(8'h18, 8'h07);
        for (k = 1; k <= edges(m); k++) begin
            if (k == edges(m)) rchk(8'h18, 8'h00);
            seed = xs(seed);
            v = seed[15:0];
            ldt(v);
            pin(1'b1);
            pin(1'b0);
        end
        rchk(8'h18, 8'h01);
        rchk(8'h15, v[7:0]);
        rchk(8'h16, v[15:8]);
        $display("test capture %h done", m);
    endtask
    // Timer starts eight counts short of the compare value
    task automatic cmp(input logic [3:0] m, input logic e);
        seed = xs(seed);
        v = seed[15:0] | 16'h0100;
        ADC_ENABLED <= seed[16];
        ldt(v - 16'h0008);
        wr(8'h15, v[7:0]);
        wr(8'h16, v[15:8]);
        wr(8'h18, 8'h07);
        wr(8'h17, {4'h0, m});
        run <= 1'b1;
        cyc(20);
        run <= 1'b0;
        chk("pin a", e, PORT_PIN_A_OUT);
        chk("pin a oe", 1'b1, PORT_PIN_A_OE);
        rchk(8'h18, 8'h02);
        if (m == 4'hB) chk("timer reset", 1'b1, WIDE_TIMER_COUNT < 16'h0020);
        $display("test compare %h done", m);
    endtask
    // After the duty has settled, any 1024 cycle window holds duty high cycles
    task automatic pwm_run;
        seed = xs(seed);
        wr(8'h15, seed[7:0]);
        wr(8'h17, {2'b00, seed[9:8], 4'hC});
        wr(8'h18, 8'h07);
        cyc(1100);
        k = 0;
        repeat (1024) begin
            cyc(1);
            if (PORT_PIN_A_OUT === 1'b1) k++;
        end
        chk("pwm high", duty_of(seed[7:0], {2'b00, seed[9:8], 4'hC}), k[15:0]);
        rchk(8'h18, 8'h04);
        wr(8'h19, 8'h04);
        cyc(2);
        chk("irq pwm", 1'b1, IRQ);
        $display("test pwm done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // Clock, watchdog and sequence
    // ****************************************
    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        repeat (30000) @(posedge SYS_CLK);
        errors++;
        conclude;
    end
    initial begin
        errors = 0;
        tests_run = 0;
        seed = 32'hA504DA4B;
        {RST_B, REG_WR, REG_RD, ADC_ENABLED, ld, run, lvl} = 7'h00;
        {REG_ADDR, REG_WDATA, ld_val} = 32'h0000_0000;
        CONFIG_WORD = 14'h0000;
        repeat (20) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        for (i = 0; i < 5; i++) rchk(8'h15 + i[7:0], 8'h00);
        seed = xs(seed);
        wr(8'h15, seed[7:0]);
        wr(8'h16, seed[15:8]);
        rchk(8'h15, seed[7:0]);
        rchk(8'h16, seed[15:8]);
        rchk(8'h1A, 8'h00);
        wr(8'h17, 8'hFF);
        rchk(8'h17, 8'h3F);
        $display("test registers done");
        for (i = 4; i < 8; i++) cap(i[3:0]);
        cmp(4'h8, 1'b1);
        cmp(4'hA, 1'b1);
        cmp(4'h9, 1'b0);
        cmp(4'hB, 1'b0);
        chk("irq masked", 1'b0, IRQ);
        wr(8'h19, 8'h02);
        cyc(2);
        chk("irq", 1'b1, IRQ);
        wr(8'h18, 8'h02);
        cyc(2);
        chk("irq cleared", 1'b0, IRQ);
        chk("flag cleared", 1'b0, UNIT_IRQ_FLAG);
        $display("test interrupt done");
        // Pin already high as capture starts must not be taken as an edge
        pin(1'b1);
        wr(8'h17, 8'h00);
        wr(8'h17, 8'h05);
        cyc(4);
        rchk(8'h18, 8'h00);
        pin(1'b0);
        $display("test capture entry done");
        pwm_run;
        @(posedge SYS_CLK);
        RST_B <= 1'b0;
        CONFIG_WORD <= 14'h1000;
        repeat (3) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        wr(8'h17, 8'h08);
        cyc(2);
        chk("pin b oe", 1'b1, PORT_PIN_B_OE);
        chk("pin a oe", 1'b0, PORT_PIN_A_OE);
        chk("pin b", 1'b1, PORT_PIN_B_OUT);
        $display("test route done");
        conclude;
    end
endmodule // tb_capture_compare_pwm_unit
`default_nettype wire
